// file: verilog/io_expander.sv
`timescale 1ns/100ps
module io_expander #(
    parameter bit FAULT_CLEAR_EN = 1'b1
) (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic [expander_pkg::PORT_W-1:0] expander_pins_in,
    output logic [expander_pkg::PORT_W-1:0] expander_pins_out,
    output logic [expander_pkg::PORT_W-1:0] expander_pins_oe_out,
    input wire logic [expander_pkg::STRAP_W-1:0] slave_addr_straps_in,
    output logic alert_n_out,
    output logic alert_n_oe_out
);
    import expander_pkg::*;

    core_state_t c_reg;
    core_state_t c_next;
    link_state_t l_reg;
    link_state_t l_next;
    logic start_tgl_reg;
    logic stop_tgl_reg;
    logic sda_oe_reg;
    logic clr_evt;

    // a bit follows its synchroniser only when the last two stages agree
    function automatic logic [PORT_W-1:0] agree(
        input logic [PORT_W-1:0] a,
        input logic [PORT_W-1:0] b,
        input logic [PORT_W-1:0] held
    );
        logic [PORT_W-1:0] r;
        r = held;
        for (int i = 0; i < PORT_W; i++) begin
            if (a[i] == b[i]) begin
                r[i] = a[i];
            end
        end
        return r;
    endfunction : agree

    function automatic logic [7:0] read_byte(
        input logic [1:0] sel,
        input logic [PORT_W-1:0] pins,
        input logic [PORT_W-1:0] pol,
        input logic [PORT_W-1:0] outv,
        input logic [PORT_W-1:0] drv
    );
        logic [7:0] r;
        r = 8'h00;
        unique case (sel)
            SEL_INPUT: r = pins ^ pol;
            SEL_OUTPUT: r = outv;
            SEL_POLARITY: r = pol;
            SEL_CONFIG: r = ~drv;
        endcase
        return r;
    endfunction : read_byte

    ////////////////////////////////////////////////////////////////////////
    // core domain: pin filtering, snapshot and alert
    always_comb begin
        logic [PORT_W-1:0] fs;
        logic [PORT_W-1:0] fl;
        fs = '0;
        fl = '0;
        c_next = c_reg;
        clr_evt = c_reg.clr_s2 ^ c_reg.clr_s3;
        c_next.pin_s1 = expander_pins_in;
        c_next.pin_s2 = c_reg.pin_s1;
        c_next.pin_s3 = c_reg.pin_s2;
        c_next.pin_f = agree(c_reg.pin_s2, c_reg.pin_s3, c_reg.pin_f);
        c_next.strap_s1 = slave_addr_straps_in;
        c_next.strap_s2 = c_reg.strap_s1;
        c_next.strap_s3 = c_reg.strap_s2;
        fs = agree({5'h00, c_reg.strap_s2}, {5'h00, c_reg.strap_s3},
                   {5'h00, c_reg.strap_f});
        c_next.strap_f = fs[STRAP_W-1:0];
        // direction is quasi-static, a plain two-stage crossing suffices
        c_next.mask_s1 = ~l_reg.drv_en;
        c_next.mask_s2 = c_reg.mask_s1;
        c_next.clr_s1 = l_reg.clr_tgl;
        c_next.clr_s2 = c_reg.clr_s1;
        c_next.clr_s3 = c_reg.clr_s2;
        if (c_reg.settle != SETTLE_CYC) begin
            // the filter shows real levels only four edges after reset;
            // counting from the second edge out of reset and loading the
            // filter's next value keeps a stale snapshot from raising a
            // false alert straight after power-up
            if (!c_reg.por) begin
                c_next.settle = c_reg.settle + 2'h1;
            end
            c_next.snap = c_next.pin_f;
        end else if (clr_evt) begin
            // snapshot takes the current levels; a change landing in the
            // same cycle is still seen next cycle against the new snapshot
            c_next.snap = c_reg.pin_f;
        end
        // outputs masked off; an output turned input compares against the old snapshot
        fl = (c_reg.pin_f ^ c_reg.snap) & c_reg.mask_s2;
        c_next.alert = (c_reg.settle == SETTLE_CYC) && (|fl);
        c_next.por = 1'b0;
        c_next.drive_low = 1'b0;
        if (!rstn_in) begin
            c_next = '0;
            c_next.por = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        c_reg <= c_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // start and stop catchers, clocked by the data line itself
    // the link clock stops between frames, so these use the core reset
    // asynchronously; a start is long settled before the next clock rise
    always_ff @(negedge sda_in or posedge c_reg.por) begin
        if (c_reg.por) begin
            start_tgl_reg <= 1'b0;
        end else if (scl_in) begin
            start_tgl_reg <= ~start_tgl_reg;
        end
    end

    always_ff @(posedge sda_in or posedge c_reg.por) begin
        if (c_reg.por) begin
            stop_tgl_reg <= 1'b0;
        end else if (scl_in) begin
            stop_tgl_reg <= ~stop_tgl_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link domain: sample on the rising clock edge
    always_comb begin
        l_next = l_reg;
        l_next.pins_s1 = c_reg.pin_f;
        l_next.pins_s2 = l_reg.pins_s1;
        l_next.strap_s1 = c_reg.strap_f;
        l_next.strap_s2 = l_reg.strap_s1;
        if (start_tgl_reg != l_reg.start_ack) begin
            // start or repeated start: this edge carries the first bit
            l_next.start_ack = start_tgl_reg;
            l_next.stop_ack = stop_tgl_reg;
            l_next.phase = PH_ADDR;
            l_next.shift = {7'h00, sda_in};
            l_next.bitcnt = 3'h1;
        end else if (stop_tgl_reg != l_reg.stop_ack) begin
            l_next.stop_ack = stop_tgl_reg;
            l_next.phase = PH_IDLE;
        end else begin
            unique case (l_reg.phase)
                PH_IDLE: begin
                    l_next.bitcnt = 3'h0;
                end
                PH_ADDR, PH_CMD, PH_WDATA: begin
                    l_next.shift = {l_reg.shift[6:0], sda_in};
                    l_next.bitcnt = l_reg.bitcnt + 3'h1;
                    if (l_reg.bitcnt == 3'h7) begin
                        if (l_reg.phase == PH_ADDR) begin
                            l_next.addr_hit = l_reg.shift[6:0] ==
                                {ADDR_HI, l_reg.strap_s2};
                            l_next.rw = sda_in;
                            l_next.phase = PH_ADDR_ACK;
                        end else if (l_reg.phase == PH_CMD) begin
                            l_next.phase = PH_CMD_ACK;
                        end else begin
                            l_next.phase = PH_WDATA_ACK;
                        end
                    end
                end
                PH_ADDR_ACK: begin
                    l_next.bitcnt = 3'h0;
                    if (l_reg.addr_hit && l_reg.rw) begin
                        l_next.phase = PH_RDATA;
                        l_next.tx = read_byte(l_reg.ptr[1:0],
                            l_reg.pins_s2, l_reg.pol, l_reg.out_val,
                            l_reg.drv_en);
                    end else if (l_reg.addr_hit) begin
                        l_next.phase = PH_CMD;
                    end else begin
                        // foreign transfer: sit out until the next start
                        l_next.phase = PH_IDLE;
                        if (FAULT_CLEAR_EN && l_reg.rw && !sda_in &&
                            l_reg.ptr == PTR_FAULT) begin
                            l_next.clr_tgl = ~l_reg.clr_tgl;
                        end
                    end
                end
                PH_CMD_ACK: begin
                    l_next.ptr = l_reg.shift;
                    l_next.bitcnt = 3'h0;
                    l_next.phase = PH_WDATA;
                end
                PH_WDATA_ACK: begin
                    // data lands on the ack rising edge
                    unique case (l_reg.ptr[1:0])
                        SEL_INPUT: l_next.out_val = l_reg.out_val;
                        SEL_OUTPUT: l_next.out_val = l_reg.shift;
                        SEL_POLARITY: l_next.pol = l_reg.shift;
                        SEL_CONFIG: l_next.drv_en = ~l_reg.shift;
                    endcase
                    l_next.bitcnt = 3'h0;
                    l_next.phase = PH_WDATA;
                end
                PH_RDATA: begin
                    l_next.bitcnt = l_reg.bitcnt + 3'h1;
                    if (l_reg.bitcnt == 3'h7) begin
                        l_next.phase = PH_RDATA_ACK;
                    end
                end
                PH_RDATA_ACK: begin
                    if (l_reg.ptr[1:0] == SEL_INPUT) begin
                        l_next.clr_tgl = ~l_reg.clr_tgl;
                    end
                    l_next.bitcnt = 3'h0;
                    if (sda_in) begin
                        l_next.phase = PH_IDLE;
                    end else begin
                        l_next.phase = PH_RDATA;
                        l_next.tx = read_byte(l_reg.ptr[1:0],
                            l_reg.pins_s2, l_reg.pol, l_reg.out_val,
                            l_reg.drv_en);
                    end
                end
                default: begin
                    l_next.phase = PH_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge scl_in or posedge c_reg.por) begin
        if (c_reg.por) begin
            l_reg <= LINK_RST;
        end else begin
            l_reg <= l_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data drive changes only while the clock is low
    always_ff @(negedge scl_in or posedge c_reg.por) begin
        if (c_reg.por) begin
            sda_oe_reg <= 1'b0;
        end else if (l_reg.phase == PH_ADDR_ACK) begin
            sda_oe_reg <= l_reg.addr_hit;
        end else if (l_reg.phase == PH_CMD_ACK ||
                     l_reg.phase == PH_WDATA_ACK) begin
            sda_oe_reg <= 1'b1;
        end else if (l_reg.phase == PH_RDATA) begin
            sda_oe_reg <= ~l_reg.tx[~l_reg.bitcnt];
        end else begin
            sda_oe_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign sda_out = c_reg.drive_low;
    assign sda_oe_out = sda_oe_reg;
    assign expander_pins_out = l_reg.out_val;
    assign expander_pins_oe_out = l_reg.drv_en;
    assign alert_n_out = c_reg.drive_low;
    assign alert_n_oe_out = c_reg.alert;

endmodule : io_expander

// file: verilog/expander_pkg.sv
package expander_pkg;

    localparam int PORT_W = 8;
    localparam int STRAP_W = 3;

    ////////////////////////////////////////////////////////////////////////
    // slave address: fixed upper nibble, straps fill the low three bits
    localparam logic [3:0] ADDR_HI = 4'h4;

    // register selects (low two bits of the stored pointer)
    localparam logic [1:0] SEL_INPUT = 2'h0;
    localparam logic [1:0] SEL_OUTPUT = 2'h1;
    localparam logic [1:0] SEL_POLARITY = 2'h2;
    localparam logic [1:0] SEL_CONFIG = 2'h3;

    // reset values; drive enable is the inverse of the all-inputs config
    localparam logic [7:0] PTR_RST = 8'h00;
    localparam logic [7:0] OUT_RST = 8'hff;
    localparam logic [7:0] POL_RST = 8'h00;
    localparam logic [7:0] DRV_RST = 8'h00;
    localparam logic [7:0] PTR_FAULT = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // timing: alert valid and alert release, both longest times
    localparam int CORE_CLK_NS = 40;
    localparam int ALERT_VALID_NS = 4000;
    localparam int ALERT_CLEAR_NS = 4000;
    localparam int ALERT_VALID_CYC = ALERT_VALID_NS / CORE_CLK_NS;
    localparam int ALERT_CLEAR_CYC = ALERT_CLEAR_NS / CORE_CLK_NS;
    localparam logic [1:0] SETTLE_CYC = 2'h3;

    typedef enum logic [3:0] {
        PH_IDLE,
        PH_ADDR,
        PH_ADDR_ACK,
        PH_CMD,
        PH_CMD_ACK,
        PH_WDATA,
        PH_WDATA_ACK,
        PH_RDATA,
        PH_RDATA_ACK
    } link_phase_t;

    typedef struct packed {
        logic [PORT_W-1:0] pin_s1;
        logic [PORT_W-1:0] pin_s2;
        logic [PORT_W-1:0] pin_s3;
        logic [PORT_W-1:0] pin_f;
        logic [STRAP_W-1:0] strap_s1;
        logic [STRAP_W-1:0] strap_s2;
        logic [STRAP_W-1:0] strap_s3;
        logic [STRAP_W-1:0] strap_f;
        logic [PORT_W-1:0] mask_s1;
        logic [PORT_W-1:0] mask_s2;
        logic clr_s1;
        logic clr_s2;
        logic clr_s3;
        logic [PORT_W-1:0] snap;
        logic [1:0] settle;
        logic alert;
        logic por;
        logic drive_low;
    } core_state_t;

    typedef struct packed {
        link_phase_t phase;
        logic [2:0] bitcnt;
        logic [7:0] shift;
        logic addr_hit;
        logic rw;
        logic [7:0] ptr;
        logic [PORT_W-1:0] out_val;
        logic [PORT_W-1:0] pol;
        logic [PORT_W-1:0] drv_en;
        logic [7:0] tx;
        logic clr_tgl;
        logic start_ack;
        logic stop_ack;
        logic [PORT_W-1:0] pins_s1;
        logic [PORT_W-1:0] pins_s2;
        logic [STRAP_W-1:0] strap_s1;
        logic [STRAP_W-1:0] strap_s2;
    } link_state_t;

    localparam link_state_t LINK_RST = '{
        phase: PH_IDLE, bitcnt: 3'h0, shift: 8'h00, addr_hit: 1'b0,
        rw: 1'b0, ptr: PTR_RST, out_val: OUT_RST, pol: POL_RST,
        drv_en: DRV_RST, tx: 8'h00, clr_tgl: 1'b0, start_ack: 1'b0,
        stop_ack: 1'b0, pins_s1: 8'h00, pins_s2: 8'h00,
        strap_s1: 3'h0, strap_s2: 3'h0};

endpackage : expander_pkg

// file: tb/io_expander_asserts.sv
`timescale 1ns/100ps
module io_expander_asserts (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic [expander_pkg::PORT_W-1:0] expander_pins_in,
    input wire logic [expander_pkg::PORT_W-1:0] expander_pins_out,
    input wire logic [expander_pkg::PORT_W-1:0] expander_pins_oe_out,
    input wire logic [expander_pkg::STRAP_W-1:0] slave_addr_straps_in,
    input wire logic alert_n_out,
    input wire logic alert_n_oe_out
);
    import expander_pkg::*;
    localparam int T_VALID = ALERT_VALID_CYC;
    logic [PORT_W-1:0] live;
    logic [PORT_W-1:0] live_d;
    logic [PORT_W-1:0] oe_d;
    logic [3:0] quiet;
    assign live = expander_pins_in & ~expander_pins_oe_out;
    // age of an idle bus with steady inputs; past 12 the alert cannot move
    always_ff @(posedge core_clk_in) begin
        live_d <= live;
        oe_d <= expander_pins_oe_out;
        if (!rstn_in || !scl_in || live != live_d
            || expander_pins_oe_out != oe_d) begin
            quiet <= 4'h0;
        end else if (quiet != 4'hf) begin
            quiet <= quiet + 4'h1;
        end
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    sequence bus_idle_s;
        scl_in [*4];
    endsequence
    sequence pin_event_s;
        $changed(live) && $stable(expander_pins_oe_out)
            && quiet >= 4'hc && !alert_n_oe_out;
    endsequence
    alert_low_a: assert property (alert_n_out == 1'b0)
        else $error("alert pin driven high");
    sda_low_a: assert property (sda_out == 1'b0)
        else $error("data pin driven high");
    reset_dflt_a: assert property (disable iff (1'b0)
        !rstn_in [*2] |-> expander_pins_out == OUT_RST && !sda_oe_out
        && expander_pins_oe_out == DRV_RST && !alert_n_oe_out)
        else $error("outputs not at reset values");
    alert_valid_a: assert property (
        pin_event_s |-> ##[1:T_VALID] alert_n_oe_out)
        else $error("alert late after input change");
    out_quiet_a: assert property (
        quiet >= 4'hc && !$past(alert_n_oe_out) |-> !alert_n_oe_out)
        else $error("alert raised without input change");
    alert_hold_a: assert property (
        quiet >= 4'hc && $past(alert_n_oe_out) |-> alert_n_oe_out)
        else $error("alert dropped without cause");
    idle_release_a: assert property (bus_idle_s |-> !sda_oe_out)
        else $error("data held low on idle bus");
    cfg_steady_a: assert property (bus_idle_s |->
        $stable(expander_pins_out) && $stable(expander_pins_oe_out))
        else $error("pin outputs moved on idle bus");
    cover property (pin_event_s);
endmodule : io_expander_asserts

bind io_expander io_expander_asserts u_chk (.core_clk_in(core_clk_in),
    .rstn_in(rstn_in), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .expander_pins_in(expander_pins_in),
    .expander_pins_out(expander_pins_out),
    .expander_pins_oe_out(expander_pins_oe_out),
    .slave_addr_straps_in(slave_addr_straps_in),
    .alert_n_out(alert_n_out), .alert_n_oe_out(alert_n_oe_out));

// file: tb/i2c_master_model.sv
`timescale 1ns/100ps
module i2c_master_model (
    output logic scl_out,
    output logic sda_low_out,
    input wire logic sda_in
);
    localparam int QTR_NS = 6;
    localparam int HALF_NS = 24;
    // clock parks high between frames; data moves only while clock is low, except for start and stop
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    task automatic start_c();
        #QTR_NS sda_low_out = 1'b0;
        #(HALF_NS - QTR_NS) scl_out = 1'b1;
        #HALF_NS sda_low_out = 1'b1;
        #HALF_NS scl_out = 1'b0;
    endtask : start_c
    task automatic bit_c(input logic low, output logic seen);
        #QTR_NS sda_low_out = low;
        #(HALF_NS - QTR_NS) scl_out = 1'b1;
        seen = sda_in;
        #HALF_NS scl_out = 1'b0;
    endtask : bit_c
    task automatic xfer(input logic [7:0] d, input logic ack_low,
        output logic [7:0] rd, output logic ak);
        for (int i = 7; i >= 0; i--) begin
            bit_c(!d[i], rd[i]);
        end
        bit_c(ack_low, ak);
    endtask : xfer
    task automatic stop_c();
        #QTR_NS sda_low_out = 1'b1;
        #(HALF_NS - QTR_NS) scl_out = 1'b1;
        #HALF_NS sda_low_out = 1'b0;
        #HALF_NS;
    endtask : stop_c
endmodule : i2c_master_model

// file: tb/test_io_expander.sv
`timescale 1ns/100ps
module test_io_expander;
    import expander_pkg::*;
    logic core_clk_in;
    logic rstn_in;
    logic scl;
    logic mst_low;
    logic sda;
    logic sda_out;
    logic sda_oe;
    logic alert_n;
    logic alert_oe;
    logic [STRAP_W-1:0] strap;
    logic [PORT_W-1:0] pin_drv;
    logic [PORT_W-1:0] pins_out;
    logic [PORT_W-1:0] pins_oe;
    logic [PORT_W-1:0] pin_lvl;
    logic [7:0] out_s, pol_s, cfg_s, rd, rd_v;
    logic ak;
    int error_cnt;
    int total_checks;
    // pull-up on the data line; undriven pins take their level from pin_drv
    assign sda = !((sda_oe && !sda_out) || mst_low);
    assign pin_lvl = (pins_oe & pins_out) | (~pins_oe & pin_drv);
    io_expander u_dut (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_out(sda_oe),
        .expander_pins_in(pin_lvl), .expander_pins_out(pins_out),
        .expander_pins_oe_out(pins_oe), .slave_addr_straps_in(strap),
        .alert_n_out(alert_n), .alert_n_oe_out(alert_oe));
    i2c_master_model u_mst (.scl_out(scl), .sda_low_out(mst_low),
        .sda_in(sda));
    initial begin
        core_clk_in = 1'b0;
        forever #20 core_clk_in = ~core_clk_in;
    end
    task automatic chk(input string what, input logic [7:0] exp,
        input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    function automatic logic [7:0] exp_reg(input logic [1:0] sel);
        logic [7:0] lvl;
        lvl = (~cfg_s & out_s) | (cfg_s & pin_drv);
        case (sel)
            SEL_INPUT: return lvl ^ pol_s;
            SEL_OUTPUT: return out_s;
            SEL_POLARITY: return pol_s;
            default: return cfg_s;
        endcase
    endfunction : exp_reg
    task automatic access(input logic [1:0] sel, input logic wr,
        input logic [7:0] wval, output logic [7:0] rval);
        u_mst.start_c();
        u_mst.xfer({ADDR_HI, strap, 1'b0}, 1'b0, rd, ak);
        chk("address ack", 8'h00, {7'h00, ak});
        u_mst.xfer({6'h00, sel}, 1'b0, rd, ak);
        chk("command ack", 8'h00, {7'h00, ak});
        if (wr) begin
            u_mst.xfer(wval, 1'b0, rd, ak);
            chk("data ack", 8'h00, {7'h00, ak});
        end else begin
            u_mst.start_c();
            u_mst.xfer({ADDR_HI, strap, 1'b1}, 1'b0, rd, ak);
            chk("read ack", 8'h00, {7'h00, ak});
            u_mst.xfer(8'hff, 1'b1, rval, ak);
            u_mst.xfer(8'hff, 1'b0, rd, ak);
            chk("second read", exp_reg(sel), rd);
        end
        u_mst.stop_c();
        @(negedge core_clk_in);
        if (wr && sel == SEL_OUTPUT) out_s = wval;
        if (wr && sel == SEL_POLARITY) pol_s = wval;
        if (wr && sel == SEL_CONFIG) cfg_s = wval;
    endtask : access
    // a read of another slave is acked by the master model standing in for that slave
    task automatic foreign(input logic rw_bit);
        u_mst.start_c();
        u_mst.xfer({4'h6, strap, rw_bit}, rw_bit, rd, ak);
        if (!rw_bit) begin
            chk("foreign ack", 8'h01, {7'h00, ak});
            u_mst.xfer(8'h00, 1'b0, rd, ak);
        end
        u_mst.stop_c();
        @(negedge core_clk_in);
    endtask : foreign
    task automatic wait_alert(input logic exp, input logic hold);
        for (int i = 0; i < ALERT_VALID_CYC && (hold || alert_oe !== exp);
            i++) @(negedge core_clk_in);
        chk("alert", {7'h00, exp}, {7'h00, alert_oe});
    endtask : wait_alert
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize
    initial begin
        #2000000;
        error_cnt++;
        summarize();
    end
    initial begin
        rstn_in = 1'b0;
        pin_drv = 8'h5a;
        error_cnt = 0;
        total_checks = 0;
        out_s = OUT_RST;
        pol_s = POL_RST;
        cfg_s = 8'hff;
        void'($urandom(22102));
        strap = 3'($urandom());
        repeat (16) @(negedge core_clk_in);
        rstn_in = 1'b1;
        repeat (20) @(negedge core_clk_in);
        chk("pins out", out_s, pins_out);
        chk("pins oe", ~cfg_s, pins_oe);
        wait_alert(1'b0, 1'b1);
        for (int s = 1; s < 4; s++) begin
            access(2'(s), 1'b0, 8'h00, rd_v);
            chk("reset read", exp_reg(2'(s)), rd_v);
        end
        $display("test reset done");
        for (int n = 0; n < 6; n++) begin
            pin_drv = 8'($urandom());
            repeat (110) @(negedge core_clk_in);
            for (int s = 0; s < 4; s++) begin
                access(2'(s), 1'b1, 8'($urandom()), rd_v);
            end
            chk("pins out", out_s, pins_out);
            chk("pins oe", ~cfg_s, pins_oe);
            for (int s = 0; s < 4; s++) begin
                access(2'(s), 1'b0, 8'h00, rd_v);
                chk("reg read", exp_reg(2'(s)), rd_v);
            end
        end
        $display("test random done");
        access(SEL_CONFIG, 1'b1, 8'hf0, rd_v);
        access(SEL_INPUT, 1'b0, 8'h00, rd_v);
        wait_alert(1'b0, 1'b1);
        pin_drv = pin_drv ^ 8'h10;
        wait_alert(1'b1, 1'b0);
        pin_drv = pin_drv ^ 8'h10;
        wait_alert(1'b0, 1'b0);
        pin_drv = pin_drv ^ 8'h01;
        access(SEL_OUTPUT, 1'b1, ~out_s, rd_v);
        wait_alert(1'b0, 1'b1);
        pin_drv = pin_drv ^ 8'h80;
        wait_alert(1'b1, 1'b0);
        foreign(1'b0);
        wait_alert(1'b1, 1'b1);
        foreign(1'b1);
        wait_alert(1'b1, 1'b1);
        access(SEL_INPUT, 1'b0, 8'h00, rd_v);
        chk("input read", exp_reg(SEL_INPUT), rd_v);
        wait_alert(1'b0, 1'b0);
        pin_drv = pin_drv ^ 8'h20;
        wait_alert(1'b1, 1'b0);
        foreign(1'b1);
        wait_alert(1'b0, 1'b0);
        pin_drv[0] = ~out_s[0];
        access(SEL_CONFIG, 1'b1, 8'hf1, rd_v);
        wait_alert(1'b1, 1'b0);
        $display("test alert done");
        summarize();
    end
endmodule : test_io_expander
